//--- verilog/fps_sched.sv
`timescale 1ns/10ps
// Behaviour
// - Poll devices one at a time, cycle after cycle while run is set
// - Only scheduler starts; replies only when waited
// - Send request, wait reply or timeout
// - Advance to next device after finish
// - After pass, zone roll-up then global
// - Drive relay coils from roll-up results
// - Device record on success; zones at roll-up
// - Broadcast pulse at the end of each cycle
// - Timeout on start, gap or total window
// - Online routine timeout: wait window, resend once
// - Second timeout abandons device, move on
// - Single retry: online routine requests only
// - Block items sent up to bring limit times, bring limit minus one retries
// - Timeouts count warnings; limit flags untrust
// - Offline limit marks offline, zone fault
module fps_sched
   import fps_pkg::*;
#(
   parameter int NDEV  = 8,
   parameter int NZONE = 4,
   parameter int NITEM = 4
)(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   output logic                    tx_req,
   output fps_req_t                tx_info,
   input  wire logic               rx_byte,
   input  wire logic               rx_done,
   input  wire logic [1:0]         rx_alarm,
   output logic [NZONE:0]          relay,
   output logic                    cast,
   output logic                    irq
);
   localparam int DW = $clog2(NDEV);
   localparam int ZW = $clog2(NZONE);
   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   logic                 run;
   logic [DW-1:0]        last;
   logic [15:0]          start_win;
   logic [15:0]          gap_win;
   logic [15:0]          tot_win;
   fps_lim_t             lim;
   logic [NIRQ-1:0]      istat;
   logic [NIRQ-1:0]      imask;
   logic [ZW-1:0]        zmap    [NDEV];
   logic [7:0]           warn_cnt[NDEV];
   logic [7:0]           off_cnt [NDEV];
   logic [1:0]           dev_al  [NDEV];
   logic [NDEV-1:0]      offline;
   logic [NDEV-1:0]      untrust;
   logic [NDEV-1:0]      blk_pend;
   logic [NZONE-1:0]     zone_al;
   logic [NZONE-1:0]     zone_flt;
   logic                 glob_al;
   logic                 glob_flt;
   fps_state_t           state;
   logic [DW-1:0]        idx;
   logic                 block;
   logic [7:0]           item;
   logic [7:0]           tries;
   logic                 got_byte;
   logic [15:0]          tcnt;
   logic [15:0]          gcnt;
   logic [NIRQ-1:0]      ev;
   logic                 wr;
   logic                 timeout;
   logic                 success;
   logic                 retry;
   logic                 fail;
   logic                 blk_last;
   logic [31:0]          next_rdata;
   logic                 next_err;
   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // Zero wait states: data is prepared in setup, so every access
   // completes in its first access cycle.
   assign wr = psel & penable & pready & pwrite;
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      case (paddr)
         A_CTRL:   next_rdata = 32'(run) | (32'(last) << CTRL_LAST);
         A_START:  next_rdata = 32'(start_win);
         A_GAP:    next_rdata = 32'(gap_win);
         A_TOTAL:  next_rdata = 32'(tot_win);
         A_LIMIT:  next_rdata = 32'(lim);
         A_ISTAT:  next_rdata = 32'(istat);
         A_IMASK:  next_rdata = 32'(imask);
         A_ZMAP: begin
            for (int d = 0; d < NDEV; d++) begin
               next_rdata[d*ZW +: ZW] = zmap[d];
            end
         end
         A_DSTAT:  next_rdata = {8'h00, 8'(blk_pend), 8'(untrust), 8'(offline)};
         A_BLKREQ: next_rdata = 32'(blk_pend);
         A_ROLL:   next_rdata = {16'h0000, 6'h00, glob_flt, glob_al, 4'(zone_flt), 4'(zone_al)};
         default:  next_err = 1'b1;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         prdata  <= (psel & ~penable & ~pwrite) ? next_rdata : 32'h0000_0000;
         pslverr <= psel & ~penable & next_err;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run       <= 1'b0;
         last      <= DW'(NDEV-1);
         start_win <= RST_START;
         gap_win   <= RST_GAP;
         tot_win   <= RST_TOTAL;
         lim       <= '{bring: RST_BRING, off: RST_OFF, warn: RST_WARN};
         imask     <= '0;
         for (int d = 0; d < NDEV; d++) begin
            zmap[d] <= '0;
         end
      end else if (wr) begin
         case (paddr)
            A_CTRL: begin
               run  <= pwdata[CTRL_RUN];
               last <= pwdata[CTRL_LAST +: DW];
            end
            A_START: start_win <= pwdata[15:0];
            A_GAP:   gap_win   <= pwdata[15:0];
            A_TOTAL: tot_win   <= pwdata[15:0];
            A_LIMIT: lim       <= pwdata[23:0];
            A_IMASK: imask     <= pwdata[NIRQ-1:0];
            A_ZMAP: begin
               for (int d = 0; d < NDEV; d++) begin
                  zmap[d] <= pwdata[d*ZW +: ZW];
               end
            end
            default: ;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   // A new event in the clearing cycle survives the write of one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat <= '0;
         irq   <= 1'b0;
      end else begin
         istat <= (istat & ~((wr && paddr == A_ISTAT) ? pwdata[NIRQ-1:0] : '0)) | ev;
         irq   <= |(istat & imask);
      end
   end
   // ----------------------------------------------------------------
   // Reply timing
   // ----------------------------------------------------------------
   assign timeout = state == S_WAIT && !rx_done &&
                    ((!got_byte && tcnt >= start_win) ||
                     (got_byte && gcnt >= gap_win) ||
                     tcnt >= tot_win);
   assign success  = state == S_WAIT && rx_done;
   assign blk_last = item == 8'(NITEM-1);
   // Block transfers retry each item; routine polls retry once, online only.
   assign retry = timeout && (block ? (tries + 8'h01 < lim.bring)
                                    : (!offline[idx] && tries == 8'h00));
   assign fail  = timeout && !retry;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcnt     <= '0;
         gcnt     <= '0;
         got_byte <= 1'b0;
      end else if (state == S_SEND) begin
         tcnt     <= '0;
         gcnt     <= '0;
         got_byte <= 1'b0;
      end else begin
         if (tcnt != 16'hFFFF) begin
            tcnt <= tcnt + 16'h0001;
         end
         if (rx_byte && state == S_WAIT) begin
            gcnt     <= '0;
            got_byte <= 1'b1;
         end else if (gcnt != 16'hFFFF) begin
            gcnt <= gcnt + 16'h0001;
         end
      end
   end
   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         idx   <= '0;
         block <= 1'b0;
         item  <= '0;
         tries <= '0;
      end else begin
         case (state)
            S_IDLE: begin
               if (run) begin
                  idx   <= '0;
                  block <= 1'b0;
                  tries <= '0;
                  state <= S_SEND;
               end
            end
            S_SEND: state <= S_WAIT;
            S_WAIT: begin
               if (success) begin
                  tries <= '0;
                  if (!block && (blk_pend[idx] || offline[idx])) begin
                     block <= 1'b1;
                     item  <= '0;
                     state <= S_SEND;
                  end else if (block && !blk_last) begin
                     item  <= item + 8'h01;
                     state <= S_SEND;
                  end else begin
                     state <= S_NEXT;
                  end
               end else if (retry) begin
                  tries <= tries + 8'h01;
                  state <= S_HOLD;
               end else if (fail) begin
                  state <= S_NEXT;
               end
            end
            S_HOLD: begin
               if (tcnt >= tot_win) begin
                  state <= S_SEND;
               end
            end
            S_NEXT: begin
               block <= 1'b0;
               tries <= '0;
               if (idx >= last) begin
                  state <= S_ZONE;
               end else begin
                  idx   <= idx + DW'(1);
                  state <= S_SEND;
               end
            end
            S_ZONE:   state <= S_GLOBAL;
            S_GLOBAL: state <= S_RELAY;
            S_RELAY:  state <= S_CAST;
            S_CAST: begin
               idx   <= '0;
               state <= run ? S_SEND : S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // Link request and broadcast mark
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_req  <= 1'b0;
         tx_info <= '0;
         cast    <= 1'b0;
      end else begin
         tx_req  <= state == S_SEND;
         tx_info <= '{block: block, item: item, addr: 8'(idx) + 8'h01};
         cast    <= state == S_RELAY;
      end
   end
   // ----------------------------------------------------------------
   // Device records
   // ----------------------------------------------------------------
   always_comb begin
      ev = '0;
      ev[IRQ_CYCLE] = state == S_CAST;
      ev[IRQ_BLOCK] = success && block && blk_last;
      ev[IRQ_WARN]  = timeout && !untrust[idx] && warn_cnt[idx] + 8'h01 >= lim.warn;
      ev[IRQ_OFF]   = fail && !offline[idx] && off_cnt[idx] + 8'h01 >= lim.off;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offline  <= '0;
         untrust  <= '0;
         blk_pend <= '0;
         for (int d = 0; d < NDEV; d++) begin
            warn_cnt[d] <= '0;
            off_cnt[d]  <= '0;
            dev_al[d]   <= '0;
         end
      end else begin
         if (wr && paddr == A_BLKREQ) begin
            blk_pend <= blk_pend | pwdata[NDEV-1:0];
         end
         if (success) begin
            if (!block) begin
               dev_al[idx] <= rx_alarm;
            end
            if (offline[idx] || untrust[idx]) begin
               warn_cnt[idx] <= '0;
               off_cnt[idx]  <= '0;
               offline[idx]  <= 1'b0;
               untrust[idx]  <= 1'b0;
            end
            if (block && blk_last) begin
               blk_pend[idx] <= 1'b0;
            end
         end
         if (timeout) begin
            if (warn_cnt[idx] != 8'hFF) begin
               warn_cnt[idx] <= warn_cnt[idx] + 8'h01;
            end
            if (ev[IRQ_WARN]) begin
               untrust[idx] <= 1'b1;
            end
         end
         if (fail) begin
            if (off_cnt[idx] != 8'hFF) begin
               off_cnt[idx] <= off_cnt[idx] + 8'h01;
            end
            if (ev[IRQ_OFF]) begin
               offline[idx] <= 1'b1;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // Roll-up and relays
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zone_al  <= '0;
         zone_flt <= '0;
         glob_al  <= 1'b0;
         glob_flt <= 1'b0;
         relay    <= '0;
      end else begin
         if (state == S_ZONE) begin
            for (int z = 0; z < NZONE; z++) begin
               zone_al[z]  <= 1'b0;
               zone_flt[z] <= 1'b0;
               for (int d = 0; d < NDEV; d++) begin
                  if (DW'(d) <= last && zmap[d] == ZW'(z)) begin
                     if (dev_al[d][0]) zone_al[z] <= 1'b1;
                     if (dev_al[d][1] || offline[d]) zone_flt[z] <= 1'b1;
                  end
               end
            end
         end
         if (state == S_GLOBAL) begin
            glob_al  <= |zone_al;
            glob_flt <= |zone_flt;
         end
         if (state == S_RELAY) begin
            relay <= {glob_al | glob_flt, zone_al | zone_flt};
         end
      end
   end
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_req_one;
      @(posedge pclk) disable iff (!presetn)
      tx_req |=> !tx_req;
   endproperty
   a_req_one: assert property (p_req_one) else $error("request longer than one cycle");
   property p_no_rx_idle;
      @(posedge pclk) disable iff (!presetn)
      $rose(got_byte) |-> $past(state) == S_WAIT && $past(rx_byte);
   endproperty
   a_no_rx_idle: assert property (p_no_rx_idle) else $error("reply byte taken outside wait");
   property p_send_wait;
      @(posedge pclk) disable iff (!presetn)
      state == S_SEND |=> state == S_WAIT ##0 tx_req;
   endproperty
   a_send_wait: assert property (p_send_wait) else $error("send not followed by wait");
   property p_start_win;
      @(posedge pclk) disable iff (!presetn)
      state == S_WAIT && !got_byte && tcnt >= start_win && !rx_done |=> state != S_WAIT;
   endproperty
   a_start_win: assert property (p_start_win) else $error("start window not enforced");
   property p_hold_win;
      @(posedge pclk) disable iff (!presetn)
      state == S_HOLD && tcnt < tot_win |=> state == S_HOLD;
   endproperty
   a_hold_win: assert property (p_hold_win) else $error("retry sent before window end");
   property p_offline_once;
      @(posedge pclk) disable iff (!presetn)
      timeout && !block && offline[idx] |=> state == S_NEXT;
   endproperty
   a_offline_once: assert property (p_offline_once) else $error("offline device retried");
   property p_rollup;
      @(posedge pclk) disable iff (!presetn)
      state == S_ZONE |=> state == S_GLOBAL ##1 state == S_RELAY ##1 cast;
   endproperty
   a_rollup: assert property (p_rollup) else $error("roll-up order broken");
   property p_relay;
      @(posedge pclk) disable iff (!presetn)
      state == S_RELAY |=> relay == {glob_al | glob_flt, zone_al | zone_flt};
   endproperty
   a_relay: assert property (p_relay) else $error("relay not updated");
   property p_untrust;
      @(posedge pclk) disable iff (!presetn)
      timeout && warn_cnt[idx] + 8'h01 >= lim.warn && lim.warn != 8'h00 |=> untrust[$past(idx)];
   endproperty
   a_untrust: assert property (p_untrust) else $error("untrust flag missing");
endmodule

//--- verilog/fps_pkg.sv
package fps_pkg;
   // ----------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_START  = 8'h04;
   localparam logic [7:0] A_GAP    = 8'h08;
   localparam logic [7:0] A_TOTAL  = 8'h0C;
   localparam logic [7:0] A_LIMIT  = 8'h10;
   localparam logic [7:0] A_ISTAT  = 8'h14;
   localparam logic [7:0] A_IMASK  = 8'h18;
   localparam logic [7:0] A_ZMAP   = 8'h1C;
   localparam logic [7:0] A_DSTAT  = 8'h20;
   localparam logic [7:0] A_BLKREQ = 8'h24;
   localparam logic [7:0] A_ROLL   = 8'h28;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_RUN  = 0;
   localparam int CTRL_LAST = 4;
   localparam int IRQ_CYCLE = 0;
   localparam int IRQ_WARN  = 1;
   localparam int IRQ_OFF   = 2;
   localparam int IRQ_BLOCK = 3;
   localparam int NIRQ      = 4;
   localparam logic [15:0] RST_START = 16'h0200;
   localparam logic [15:0] RST_GAP   = 16'h0100;
   localparam logic [15:0] RST_TOTAL = 16'h2000;
   localparam logic [7:0]  RST_WARN  = 8'h03;
   localparam logic [7:0]  RST_OFF   = 8'h03;
   localparam logic [7:0]  RST_BRING = 8'h14;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] bring;
      logic [7:0] off;
      logic [7:0] warn;
   } fps_lim_t;
   typedef struct packed {
      logic       block;
      logic [7:0] item;
      logic [7:0] addr;
   } fps_req_t;
   typedef enum logic [3:0] {
      S_IDLE, S_SEND, S_WAIT, S_HOLD, S_NEXT,
      S_ZONE, S_GLOBAL, S_RELAY, S_CAST
   } fps_state_t;
endpackage

//--- verif/fps_slave.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Remote transmitter loop model
// ----------------------------------------------------------------
// Answers one request at a time, so a silent device shows up as
// a missing reply and never as a late reply into the next slot.
module fps_slave
   import fps_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tx_req,
   input  wire fps_req_t   tx_info,
   input  wire logic [7:0] silent,
   input  wire logic [7:0] alarm,
   input  wire logic       slow,
   input  wire logic       blk_mute,
   output logic            rx_byte,
   output logic            rx_done,
   output logic [1:0]      rx_alarm
);
   logic [2:0] idx;
   initial begin
      rx_byte = 1'b0;
      rx_done = 1'b0;
      rx_alarm = 2'b11;
      forever begin
         @(posedge pclk);
         if (presetn === 1'b1 && tx_req === 1'b1) begin
            idx = tx_info.addr[2:0] - 3'd1;
            // Muting only block items lets the bench use up the item retry budget.
            if (silent[idx] !== 1'b1 && !(blk_mute === 1'b1 && tx_info.block === 1'b1)) begin
               repeat (slow ? 6 : 1) @(posedge pclk);
               for (int i = 0; i < 3; i++) begin
                  rx_byte <= 1'b1;
                  @(posedge pclk);
                  rx_byte <= 1'b0;
                  @(posedge pclk);
               end
               rx_alarm <= {1'b0, alarm[idx]};
               rx_done <= 1'b1;
               @(posedge pclk);
               rx_done <= 1'b0;
               rx_alarm <= ~{1'b0, alarm[idx]};
            end
         end
      end
   end
endmodule

//--- verif/fieldbus_poll_scheduler_tb.sv
`timescale 1ns/10ps
module fieldbus_poll_scheduler_tb;
   import fps_pkg::*;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic        e;
   } fps_row_t;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, silent, alarm;
   logic [31:0] pwdata, prdata, q_s;
   logic        tx_req, rx_byte, rx_done, cast, irq, slow, e_s, blk_mute;
   logic [1:0]  rx_alarm;
   logic [4:0]  relay;
   fps_req_t    tx_info;
   fps_req_t    log_q[$];
   int          t_q[$];
   int          cyc = 0;
   int          k;
   int          err_total = 0;
   int          n_compared = 0;
   fps_row_t    rows [10] = '{'{A_CTRL, 32'h70, 1'b0}, '{A_START, 32'h200, 1'b0},
      '{A_GAP, 32'h100, 1'b0}, '{A_TOTAL, 32'h2000, 1'b0}, '{A_LIMIT, 32'h140303, 1'b0},
      '{A_ISTAT, 32'h0, 1'b0}, '{A_IMASK, 32'h0, 1'b0}, '{A_DSTAT, 32'h0, 1'b0},
      '{A_ROLL, 32'h0, 1'b0}, '{8'h2C, 32'h0, 1'b1}};

   fps_sched dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .tx_req(tx_req), .tx_info(tx_info), .rx_byte(rx_byte), .rx_done(rx_done), .rx_alarm(rx_alarm),
      .relay(relay), .cast(cast), .irq(irq));
   fps_slave model (.pclk(pclk), .presetn(presetn), .tx_req(tx_req), .tx_info(tx_info), .silent(silent),
      .alarm(alarm), .slow(slow), .blk_mute(blk_mute), .rx_byte(rx_byte), .rx_done(rx_done), .rx_alarm(rx_alarm));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (tx_req === 1'b1) begin
         log_q.push_back(tx_info);
         t_q.push_back(cyc);
      end
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("counts: %0d compared, %0d mismatches", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic hang();
      err_total++;
      $display("mismatch at %0t: wait ran out", $time);
      complete_run();
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q_s = prdata;
      e_s = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) hang();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(q_s, exp);
   endtask

   // The loop keeps running during waits, so every wait is capped.
   task automatic wait_cast();
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (cast !== 1'b1 && n < 3000);
      if (n >= 3000) hang();
      $display("test poll cycle done at %0t", $time);
   endtask

   task automatic check_log(input logic [39:0] e, input int n);
      check(32'(log_q.size()), 32'(n));
      for (int i = 0; i < n && i < log_q.size(); i++) begin
         check({24'h0, log_q[i].addr}, {24'h0, e[8*(n-1-i)+:8]});
      end
      log_q.delete();
      t_q.delete();
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      silent = 8'h04;
      alarm = 8'h02;
      slow = 1'b0;
      blk_mute = 1'b0;
      repeat (3) @(posedge pclk);
      check({23'h0, tx_req, cast, irq, pready, relay}, 32'h0);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0);
         check(q_s, rows[i].d);
         check({31'h0, e_s}, {31'h0, rows[i].e});
      end
      $display("test reset values done");
      wr(A_START, 32'h8);
      wr(A_GAP, 32'h8);
      wr(A_TOTAL, 32'h28);
      wr(A_LIMIT, 32'h030202);
      wr(A_ZMAP, 32'hE4);
      wr(A_DSTAT, 32'hFF);
      rd_chk(A_DSTAT, 32'h0);
      wr(A_CTRL, 32'h31);
      wait_cast();
      check(32'(t_q.size() > 3 && t_q[3] - t_q[2] >= 40), 32'h1);
      check_log(40'h0102030304, 5);
      check({27'h0, relay}, 32'h12);
      check({31'h0, irq}, 32'h0);
      rd_chk(A_DSTAT, 32'h400);
      rd_chk(A_ROLL, 32'h102);
      wait_cast();
      check_log(40'h0102030304, 5);
      check({27'h0, relay}, 32'h16);
      rd_chk(A_DSTAT, 32'h404);
      rd_chk(A_ROLL, 32'h342);
      rd_chk(A_ISTAT, 32'h7);
      slow <= 1'b1;
      wait_cast();
      silent <= 8'h00;
      alarm <= 8'h00;
      slow <= 1'b0;
      check_log(40'h01020304, 4);
      wait_cast();
      check({27'h0, relay}, 32'h0);
      apb(1'b0, A_DSTAT, 32'h0);
      check(q_s & 32'hFFFF, 32'h0);
      wr(A_BLKREQ, 32'h1);
      log_q.delete();
      wait_cast();
      wait_cast();
      k = 0;
      foreach (log_q[i]) begin
         if (log_q[i].block === 1'b1 && log_q[i].addr === 8'h01) begin
            check({24'h0, log_q[i].item}, 32'(k));
            k++;
         end
      end
      check(32'(k), 32'h4);
      apb(1'b0, A_ISTAT, 32'h0);
      check(q_s & 32'h8, 32'h8);
      $display("test block transfer done");
      // Muted items must stop at the bring limit, not retry forever.
      blk_mute <= 1'b1;
      wr(A_BLKREQ, 32'h1);
      log_q.delete();
      wait_cast();
      k = 0;
      foreach (log_q[i]) begin
         if (log_q[i].block === 1'b1) begin
            check({24'h0, log_q[i].item}, 32'h0);
            k++;
         end
      end
      check(32'(k), 32'h3);
      $display("test block retry limit done");
      // Stop polling first, or a fresh cycle event would re-raise the line.
      wr(A_CTRL, 32'h30);
      repeat (400) @(posedge pclk);
      wr(A_IMASK, 32'hF);
      repeat (3) @(posedge pclk);
      check({31'h0, irq}, 32'h1);
      wr(A_ISTAT, 32'hF);
      repeat (3) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      rd_chk(A_ISTAT, 32'h0);
      $display("test interrupt done");
      complete_run();
   end
endmodule
